/* design/psa_addressing.sv */
// Program-space address forming for fetch, table access and the read-only window.
// Assumes requests are synchronous to clock_in; coinciding requests are arbitrated (fetch, then table, then window) and flagged.
//
// Summary of operation
// - Program words 24 bits, data words 16
// - Fetch, table and window reach program space
// - Table access: bytes or words, read/write
// - Table access reaches the upper byte
// - Window is read-only, writes dropped
// - Window returns only the low word
// - Fetch address: 0, PC 22:1, 0
// - Table address: page over effective address
// - Page top bit selects configuration space
`include "psa_regs.svh"
module psa_addressing #(
  parameter int MEM_AW = 12
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic fetch_req_in,
  input wire logic [`PSA_PC_W-1:0] pc_in,
  input wire logic page_we_in,
  input wire logic [`PSA_PAGE_W-1:0] page_wdata_in,
  input wire psa_pkg::psa_tbl_req_s tbl_in,
  input wire psa_pkg::psa_win_req_s win_in,
  input wire logic [`PSA_PAGE_W-1:0] vis_page_in,
  output logic [`PSA_PAGE_W-1:0] table_page_register_out,
  output logic [`PSA_PS_W-1:0] ps_addr_out,
  output logic cfg_space_out,
  output logic [`PSA_PS_W-1:0] fetch_word_out,
  output logic fetch_valid_out,
  output logic [`PSA_DS_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic win_wr_blocked_out,
  output logic collision_out
);
  psa_pkg::psa_kind_e next_kind;
  psa_pkg::psa_kind_e s1_kind;
  logic [`PSA_PS_W-1:0] fetch_addr;
  logic [`PSA_PS_W-1:0] tbl_addr;
  logic [`PSA_PS_W-1:0] win_addr;
  logic [`PSA_PS_W-1:0] next_addr;
  logic [`PSA_LANES-1:0] mem_we;
  logic [`PSA_PS_W-1:0] mem_wdata;
  logic [`PSA_PS_W-1:0] mem_rdata;
  logic [MEM_AW-1:0] mem_addr;
  logic s1_write;
  logic s1_byte;
  logic s1_high;
  logic s1_lsb;
  logic [`PSA_DS_W-1:0] next_rd;

  // ==========================================
  // Address forming
  // fetch address form
  assign fetch_addr = {1'b0, pc_in[`PSA_PC_W-1:1], 1'b0};
  assign tbl_addr = {table_page_register_out, tbl_in.ea};
  // Window maps into user space only, so configuration words stay hidden
  assign win_addr = {1'b0, vis_page_in, win_in.ea[`PSA_VIS_OFS_W-1:0]};

  // ==========================================
  // Request selection
  // three access paths
  always_comb begin
    next_kind = psa_pkg::PSA_IDLE;
    next_addr = '0;
    if (fetch_req_in) begin
      next_kind = psa_pkg::PSA_FETCH;
      next_addr = fetch_addr;
    end else if (tbl_in.req) begin
      next_kind = psa_pkg::PSA_TABLE;
      next_addr = tbl_addr;
    end else if (win_in.req) begin
      next_kind = psa_pkg::PSA_WINDOW;
      next_addr = win_addr;
    end
  end

  assign mem_addr = {next_addr[`PSA_SPACE_BIT], next_addr[MEM_AW-1:1]};

  // ==========================================
  // Write lanes
  // byte or word writes
  always_comb begin
    mem_we = `PSA_WE_NONE;
    mem_wdata = {tbl_in.wdata[`PSA_BYTE_W-1:0], tbl_in.wdata};
    if (next_kind == psa_pkg::PSA_TABLE && tbl_in.write) begin
      if (tbl_in.byte_mode) begin
        mem_wdata = {3{tbl_in.wdata[`PSA_BYTE_W-1:0]}};
        if (tbl_in.high) begin
          // The odd byte of the upper half does not exist; writing it is dropped
          mem_we = tbl_in.ea[0] ? `PSA_WE_NONE : `PSA_WE_B2;
        end else begin
          mem_we = tbl_in.ea[0] ? `PSA_WE_B1 : `PSA_WE_B0;
        end
      end else begin
        mem_we = tbl_in.high ? `PSA_WE_B2 : `PSA_WE_LOW;
      end
    end
  end

  psa_program_mem #(
    .AW(MEM_AW)
  ) u_mem (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .enable_in(enable_in),
    .addr_in(mem_addr),
    .we_in(mem_we),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  // ==========================================
  // Page register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      table_page_register_out <= `PSA_PAGE_RST;
    end else if (enable_in && page_we_in) begin
      table_page_register_out <= page_wdata_in;
    end
  end

  // ==========================================
  // Request stage
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_kind <= psa_pkg::PSA_IDLE;
      s1_write <= 1'b0;
      s1_byte <= 1'b0;
      s1_high <= 1'b0;
      s1_lsb <= 1'b0;
      ps_addr_out <= '0;
      cfg_space_out <= 1'b0;
      win_wr_blocked_out <= 1'b0;
      collision_out <= 1'b0;
    end else if (enable_in) begin
      s1_kind <= next_kind;
      s1_write <= (next_kind == psa_pkg::PSA_TABLE) ? tbl_in.write : win_in.write;
      s1_byte <= tbl_in.byte_mode;
      s1_high <= tbl_in.high;
      s1_lsb <= tbl_in.ea[0];
      // Address and space flag hold between requests
      if (next_kind != psa_pkg::PSA_IDLE) begin
        ps_addr_out <= next_addr;
        cfg_space_out <= next_addr[`PSA_SPACE_BIT];
      end
      win_wr_blocked_out <= (next_kind == psa_pkg::PSA_WINDOW) && win_in.write;
      collision_out <= (fetch_req_in && (tbl_in.req || win_in.req)) || (tbl_in.req && win_in.req);
    end
  end

  // ==========================================
  // Read formatting
  // upper byte readable
  always_comb begin
    next_rd = mem_rdata[`PSA_DS_W-1:0];
    if (s1_kind == psa_pkg::PSA_TABLE) begin
      if (s1_high) begin
        next_rd = (s1_byte && s1_lsb) ? '0 : {8'h00, mem_rdata[`PSA_PS_W-1:`PSA_DS_W]};
      end else if (s1_byte) begin
        next_rd = {8'h00, s1_lsb ? mem_rdata[`PSA_DS_W-1:`PSA_BYTE_W]
                                 : mem_rdata[`PSA_BYTE_W-1:0]};
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fetch_word_out <= '0;
      fetch_valid_out <= 1'b0;
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else if (enable_in) begin
      fetch_valid_out <= 1'b0;
      rd_valid_out <= 1'b0;
      unique case (s1_kind)
        psa_pkg::PSA_IDLE: begin
        end
        psa_pkg::PSA_FETCH: begin
          fetch_word_out <= mem_rdata;
          fetch_valid_out <= 1'b1;
        end
        psa_pkg::PSA_TABLE, psa_pkg::PSA_WINDOW: begin
          if (!s1_write) begin
            rd_data_out <= next_rd;
            rd_valid_out <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  a_fetch_addr_form: assert property (enable_in && fetch_req_in |=>
    ps_addr_out == {1'b0, $past(pc_in[`PSA_PC_W-1:1]), 1'b0}) else $error("fetch address wrong");
  a_table_addr_form: assert property (enable_in && !fetch_req_in && tbl_in.req |=>
    ps_addr_out == {$past(table_page_register_out), $past(tbl_in.ea)})
    else $error("table address wrong");
  a_space_select: assert property (enable_in && !fetch_req_in && tbl_in.req |=>
    cfg_space_out == $past(table_page_register_out[`PSA_PAGE_TOP]))
    else $error("space select wrong");
  a_fetch_two_cycles: assert property ((enable_in && fetch_req_in) ##1 enable_in |=>
    fetch_valid_out && fetch_word_out == $past(mem_rdata)) else $error("fetch not returned");
  a_write_only_table: assert property (mem_we != `PSA_WE_NONE |->
    next_kind == psa_pkg::PSA_TABLE && tbl_in.write) else $error("stray program write");
  // The read pulse of a refused write would show one cycle after the flag
  a_window_blocked: assert property ((enable_in && !fetch_req_in && !tbl_in.req
    && win_in.req && win_in.write) ##1 enable_in |-> win_wr_blocked_out ##1 !rd_valid_out)
    else $error("window write not refused");
  a_window_low_word: assert property (enable_in && s1_kind == psa_pkg::PSA_WINDOW
    && !s1_write |=> rd_valid_out && rd_data_out == $past(mem_rdata[`PSA_DS_W-1:0]))
    else $error("window data wrong");
  a_upper_byte_read: assert property (enable_in && s1_kind == psa_pkg::PSA_TABLE
    && s1_high && !s1_write && !s1_byte
    |=> rd_data_out == {8'h00, $past(mem_rdata[`PSA_PS_W-1:`PSA_DS_W])})
    else $error("upper byte wrong");
  a_byte_lane_pick: assert property (next_kind == psa_pkg::PSA_TABLE && tbl_in.write
    && tbl_in.byte_mode && !tbl_in.high |-> mem_we == (tbl_in.ea[0] ? `PSA_WE_B1 : `PSA_WE_B0))
    else $error("byte lane wrong");
  a_word_lanes: assert property (next_kind == psa_pkg::PSA_TABLE && tbl_in.write
    && !tbl_in.byte_mode && !tbl_in.high |-> mem_we == `PSA_WE_LOW) else $error("word lanes");

  c_fetch: cover property (enable_in && fetch_req_in ##1 enable_in ##1 fetch_valid_out);
  c_table_byte_write: cover property (mem_we == `PSA_WE_B1);
  c_config_read: cover property (cfg_space_out ##1 rd_valid_out);
  c_window_blocked: cover property (win_wr_blocked_out);
endmodule // psa_addressing

/* design/psa_regs.svh */
// Constants for the program-space access block: widths and field positions.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef PSA_REGS_SVH
`define PSA_REGS_SVH
`define PSA_PS_W 24
`define PSA_DS_W 16
`define PSA_PAGE_W 8
`define PSA_EA_W 16
`define PSA_PC_W 23
`define PSA_SPACE_BIT 23
`define PSA_PAGE_TOP 7
`define PSA_BYTE_W 8
`define PSA_LANES 3
`define PSA_VIS_OFS_W 15
`define PSA_PAGE_RST 8'h00
`define PSA_WE_NONE 3'h0
`define PSA_WE_B0 3'h1
`define PSA_WE_B1 3'h2
`define PSA_WE_B2 3'h4
`define PSA_WE_LOW 3'h3
`endif

/* design/psa_pkg.sv */
// Types shared by the program-space access block.
// Assumes psa_regs.svh is on the include path.
`include "psa_regs.svh"
package psa_pkg;
  typedef enum logic [3:0] {
    PSA_IDLE = 4'h1,
    PSA_FETCH = 4'h2,
    PSA_TABLE = 4'h4,
    PSA_WINDOW = 4'h8
  } psa_kind_e;
  typedef struct packed {
    logic req;
    logic write;
    logic byte_mode;
    logic high;
    logic [`PSA_EA_W-1:0] ea;
    logic [`PSA_DS_W-1:0] wdata;
  } psa_tbl_req_s;
  typedef struct packed {
    logic req;
    logic write;
    logic [`PSA_EA_W-1:0] ea;
  } psa_win_req_s;
endpackage : psa_pkg

/* design/psa_program_mem.sv */
// Program word store with three byte lanes and a registered read port.
// Assumes one access per enabled cycle; a read during a write returns the old word.
`include "psa_regs.svh"
module psa_program_mem #(
  parameter int AW = 12
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [`PSA_LANES-1:0] we_in,
  input wire logic [`PSA_PS_W-1:0] wdata_in,
  output logic [`PSA_PS_W-1:0] rdata_out
);
  logic [`PSA_PS_W-1:0] mem [0:(1<<AW)-1];

  // ==========================================
  // Lane writes
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < `PSA_LANES; i++) begin
      if (enable_in && we_in[i]) begin
        mem[addr_in][i*`PSA_BYTE_W +: `PSA_BYTE_W] <= wdata_in[i*`PSA_BYTE_W +: `PSA_BYTE_W];
      end
    end
  end

  // ==========================================
  // Registered read
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (enable_in) begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule // psa_program_mem

/* test/psa_core_model.sv */
// Core-side request source: kinds 0 to 2 are fetch, table, window; 3 and 4 raise two at once.
// Assumes the caller waits for each answer before the next call.
`include "psa_regs.svh"
module psa_core_model (
  input wire logic clock_in,
  output logic fetch_req_out,
  output logic [`PSA_PC_W-1:0] pc_out,
  output psa_pkg::psa_tbl_req_s tbl_out,
  output psa_pkg::psa_win_req_s win_out,
  output logic [7:0] vis_page_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fetch_req_out = 1'b0;
    pc_out = '0;
    tbl_out = '0;
    win_out = '0;
    vis_page_out = 8'h00;
  end
  // ==========================================
  // Request issue
  // One-cycle requests; kinds 3 and 4 raise two at once
  task automatic issue(input int kind, input logic wr, input logic bm, input logic hi,
                       input logic [15:0] ea, input logic [15:0] wd,
                       input logic [22:0] pc, input logic [7:0] vp);
    @(posedge clock_in);
    fetch_req_out <= (kind == 0 || kind == 3);
    pc_out <= pc;
    vis_page_out <= vp;
    tbl_out <= '{req: (kind == 1 || kind >= 3), write: wr, byte_mode: bm, high: hi, ea: ea,
                 wdata: wd};
    win_out <= '{req: (kind == 2 || kind == 4), write: wr, ea: ea};
    @(posedge clock_in);
    // Released fields flip so stale values never look valid
    fetch_req_out <= 1'b0;
    pc_out <= ~pc;
    tbl_out <= '{req: 1'b0, write: ~wr, byte_mode: ~bm, high: ~hi, ea: ~ea, wdata: ~wd};
    win_out <= '{req: 1'b0, write: ~wr, ea: ~ea};
  endtask
endmodule // psa_core_model

/* test/tb_program_space_access_addressing.sv */
// Self-checking bench for program-space address forming, with a word-array model.
// Assumes the design package and psa_core_model are compiled first.
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_program_space_access_addressing;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 6;
  logic clock_in, nrst_in, page_we, fetch_req, cfg, fetch_valid, rd_valid, blocked, collision;
  logic en;
  logic [7:0] page_wd, vis_page, page_reg, page;
  logic [22:0] pc;
  logic [23:0] ps_addr, fetch_word;
  logic [15:0] rd_data;
  psa_pkg::psa_tbl_req_s tbl;
  psa_pkg::psa_win_req_s win;
  logic [23:0] mem [int];
  int err_total, checks_done;
  psa_core_model core (.clock_in(clock_in), .fetch_req_out(fetch_req), .pc_out(pc),
    .tbl_out(tbl), .win_out(win), .vis_page_out(vis_page));
  psa_addressing #(.MEM_AW(AW)) dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .enable_in(en), .fetch_req_in(fetch_req), .pc_in(pc), .page_we_in(page_we),
    .page_wdata_in(page_wd), .tbl_in(tbl), .win_in(win), .vis_page_in(vis_page),
    .table_page_register_out(page_reg), .ps_addr_out(ps_addr), .cfg_space_out(cfg),
    .fetch_word_out(fetch_word), .fetch_valid_out(fetch_valid), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .win_wr_blocked_out(blocked), .collision_out(collision));
  // ==========================================
  // Clock and closing
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run needs about 1500 cycles; the limit leaves ample slack
  initial begin
    #(50 * 20000);
    err_total++;
    end_of_test();
  end
  // ==========================================
  // Model: words indexed by space bit and low address bits
  function automatic int idx(input logic [23:0] a);
    return int'({a[23], a[AW-1:1]});
  endfunction
  task automatic load_page(input logic [7:0] v);
    @(posedge clock_in);
    page_we <= 1'b1;
    page_wd <= v;
    @(posedge clock_in);
    page_we <= 1'b0;
    page = v;
    #1;
    `CHK("table page", v, page_reg)
  endtask
  task automatic run(input int req, input logic wr, input logic bm, input logic hi,
                     input logic [15:0] ea, input logic [15:0] wd,
                     input logic [22:0] p, input logic [7:0] vp);
    logic [23:0] a, w;
    logic [15:0] exp_rd;
    int kind;
    // Colliding requests: fetch beats table, table beats window
    kind = (req == 3) ? 0 : (req == 4) ? 1 : req;
    a = (kind == 0) ? {1'b0, p[22:1], 1'b0} : (kind == 1) ? {page, ea} : {1'b0, vp, ea[14:0]};
    w = mem.exists(idx(a)) ? mem[idx(a)] : 24'h0;
    if (kind == 1 && wr) begin
      if (!hi && !bm) w[15:0] = wd;
      else if (!hi) w[8*ea[0] +: 8] = wd[7:0];
      else if (!(bm && ea[0])) w[23:16] = wd[7:0];
      mem[idx(a)] = w;
    end
    if (kind == 1 && !hi) exp_rd = bm ? {8'h00, w[8*ea[0] +: 8]} : w[15:0];
    else if (kind == 1) exp_rd = (bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
    else exp_rd = w[15:0];
    core.issue(req, wr, bm, hi, ea, wd, p, vp);
    #1;
    `CHK("address", a, ps_addr)
    `CHK("config space", a[23], cfg)
    `CHK("window write refused", (kind == 2 && wr), blocked)
    `CHK("collision", (req >= 3), collision)
    @(posedge clock_in);
    #1;
    if (kind == 0) begin
      `CHK("fetch valid", 1'b1, fetch_valid)
      `CHK("fetch word", w, fetch_word)
    end else if (wr) begin
      `CHK("read valid on write", 1'b0, rd_valid)
    end else begin
      `CHK("read valid", 1'b1, rd_valid)
      `CHK("read data", exp_rd, rd_data)
    end
  endtask
  // Clock enable low: a fetch and a page load are ignored, every output holds
  task automatic freeze(input logic [7:0] v, input logic [22:0] p);
    logic [23:0] a0, f0;
    logic [15:0] d0;
    @(posedge clock_in);
    en <= 1'b0;
    page_we <= 1'b1;
    page_wd <= v;
    #1;
    a0 = ps_addr;
    f0 = fetch_word;
    d0 = rd_data;
    core.issue(0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, p, 8'h00);
    @(posedge clock_in);
    en <= 1'b1;
    page_we <= 1'b0;
    #1;
    `CHK("frozen page", page, page_reg)
    `CHK("frozen address", a0, ps_addr)
    `CHK("frozen fetch word", f0, fetch_word)
    `CHK("frozen fetch valid", 1'b0, fetch_valid)
    `CHK("frozen read data", d0, rd_data)
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r0, r1;
    nrst_in = 1'b0;
    page_we = 1'b0;
    en = 1'b1;
    page_wd = 8'h00;
    page = 8'h00;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'he05526ec));
    repeat (4) @(posedge clock_in);
    #1;
    `CHK("page in reset", 8'h00, page_reg)
    `CHK("address in reset", 24'h000000, ps_addr)
    @(posedge clock_in);
    nrst_in <= 1'b1;
    // Fill both spaces so every later read has a known word
    for (int s = 0; s < 2; s++) begin
      load_page(s ? 8'h80 : 8'h00);
      for (int i = 0; i < 64; i += 2) begin
        r0 = $urandom;
        run(1, 1'b1, 1'b0, 1'b0, 16'(i), r0[15:0], 23'h0, 8'h00);
        run(1, 1'b1, 1'b0, 1'b1, 16'(i), r0[31:16], 23'h0, 8'h00);
      end
    end
    repeat (300) begin
      r0 = $urandom;
      r1 = $urandom;
      if (r1[2:0] == 3'h0) load_page(r1[15:8]);
      if (r1[5:3] == 3'h0) freeze(r1[15:8], r1[31:9]);
      run($urandom_range(4), r0[0], r0[1], r0[2], r0[18:3], r1[15:0], r1[31:9], r0[26:19]);
    end
    end_of_test();
  end
endmodule // tb_program_space_access_addressing
